// *** verilog/standby_defines.svh ***
// Summary of operation
// - Halt stops the CPU, peripherals keep running.
// - Halt entry leaves every oscillator unchanged.
// - Halt ends on reset pin, reset, interrupt.
// - Full hold stops CPU and all peripherals.
// - Full hold stops PLL, resonator, RC, crystal.
// - Low-speed RC stays under watchdog control.
// - Full hold wakes on seven listed sources.
// - Lines zero, one wake hold only level-configured.
// - Crystal hold keeps base timer, IR receiver.
// - Crystal hold stops PLL, resonator, RC oscillators.
// - Low RC keeps entry state for base timer.
// - Crystal keeps its entry state in crystal hold.
// - Crystal hold wakes on nine listed sources.
// - Lines zero, one need level mode there too.
// - Power-on reset asserts when power appears.
// - Power-on release level: one of eight.
// - Internal reset joins power-on and supply drop.
// - Supply-drop reset: enable, one of seven levels.
`ifndef STANDBY_DEFINES_SVH
`define STANDBY_DEFINES_SVH

// ----------------------------------------------------------------
// Timing
// ----------------------------------------------------------------
`define SBY_CLK_PERIOD_NS        40
`define SBY_RESET_STRETCH_NS     1000
`define SBY_RESET_STRETCH_CYCLES ((`SBY_RESET_STRETCH_NS + `SBY_CLK_PERIOD_NS - 1) / `SBY_CLK_PERIOD_NS)
`define SBY_OSC_RESTART_NS       100000
`define SBY_OSC_RESTART_CYCLES   ((`SBY_OSC_RESTART_NS + `SBY_CLK_PERIOD_NS - 1) / `SBY_CLK_PERIOD_NS)
`define SBY_COUNT_ONE            16'h0001
`define SBY_COUNT_ZERO           16'h0000

// ----------------------------------------------------------------
// Supply thresholds in millivolts
// ----------------------------------------------------------------
`define SBY_POR_MV_0 13'h0686
`define SBY_POR_MV_1 13'h07B2
`define SBY_POR_MV_2 13'h0816
`define SBY_POR_MV_3 13'h0942
`define SBY_POR_MV_4 13'h0A0A
`define SBY_POR_MV_5 13'h0B36
`define SBY_POR_MV_6 13'h0F14
`define SBY_POR_MV_7 13'h10FE
`define SBY_LVD_MV_0 13'h0776
`define SBY_LVD_MV_1 13'h07DA
`define SBY_LVD_MV_2 13'h0906
`define SBY_LVD_MV_3 13'h09CE
`define SBY_LVD_MV_4 13'h0AFA
`define SBY_LVD_MV_5 13'h0ECE
`define SBY_LVD_MV_6 13'h10B8

`endif

// *** verilog/standby_pkg.sv ***
package standby_pkg;

    // ----------------------------------------------------------------
    // Sequencer states, one-hot.
    // ----------------------------------------------------------------
    typedef enum logic [5:0] {
        ST_RUN     = 6'h01,
        ST_HALT    = 6'h02,
        ST_HOLD    = 6'h04,
        ST_XHOLD   = 6'h08,
        ST_RESTART = 6'h10,
        ST_RESET   = 6'h20
    } sby_state_t;

    // Supply monitor state.
    typedef struct packed {
        logic power_on_pending;  // Power-on reset still waiting for release level.
        logic supply_reset;      // Registered combined reset.
    } supply_regs_t;

endpackage

// *** verilog/supply_reset_gen.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "standby_defines.svh"
module supply_reset_gen
    import standby_pkg::*;
(
    input  wire logic        ref_clk,
    input  wire logic        srst,
    input  wire logic [12:0] supply_mv,
    input  wire logic [2:0]  por_level_select,
    input  wire logic        supply_drop_enable,
    input  wire logic [2:0]  supply_drop_level_select,
    output logic             supply_reset
);
    supply_regs_t s;
    supply_regs_t next_s;

    // Release levels for power-on; the eight codes map one to one.
    function automatic logic [12:0] por_level(input logic [2:0] sel);
        case (sel)
            3'h0: por_level = `SBY_POR_MV_0;
            3'h1: por_level = `SBY_POR_MV_1;
            3'h2: por_level = `SBY_POR_MV_2;
            3'h3: por_level = `SBY_POR_MV_3;
            3'h4: por_level = `SBY_POR_MV_4;
            3'h5: por_level = `SBY_POR_MV_5;
            3'h6: por_level = `SBY_POR_MV_6;
            default: por_level = `SBY_POR_MV_7;
        endcase
    endfunction

    // Seven drop levels; the unused eighth code falls to the highest one.
    function automatic logic [12:0] drop_level(input logic [2:0] sel);
        case (sel)
            3'h0: drop_level = `SBY_LVD_MV_0;
            3'h1: drop_level = `SBY_LVD_MV_1;
            3'h2: drop_level = `SBY_LVD_MV_2;
            3'h3: drop_level = `SBY_LVD_MV_3;
            3'h4: drop_level = `SBY_LVD_MV_4;
            3'h5: drop_level = `SBY_LVD_MV_5;
            default: drop_level = `SBY_LVD_MV_6;
        endcase
    endfunction

    // Next state of the monitor.
    always_comb begin
        next_s = s;
        if (supply_mv >= por_level(por_level_select)) begin
            next_s.power_on_pending = 1'b0;
        end
        next_s.supply_reset = next_s.power_on_pending |
                              (supply_drop_enable && (supply_mv < drop_level(supply_drop_level_select)));
    end

    // Reset models power arrival; the pending flag starts set.
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            s <= '{power_on_pending: 1'b1, supply_reset: 1'b1};
        end else begin
            s <= next_s;
        end
    end

    assign supply_reset = s.supply_reset;
endmodule
`default_nettype wire

// *** verilog/wake_source_filter.sv ***
`timescale 1ns/1ps
`default_nettype none
module wake_source_filter (
    input  wire logic any_irq,
    input  wire logic external_irq_line_zero,
    input  wire logic external_irq_line_one,
    input  wire logic external_irq_line_two,
    input  wire logic external_irq_line_four,
    input  wire logic external_irq_line_five,
    input  wire logic line_zero_level_mode,
    input  wire logic line_one_level_mode,
    input  wire logic port_zero_irq,
    input  wire logic usb_bus_active_irq,
    input  wire logic base_timer_irq,
    input  wire logic ir_receiver_irq,
    output logic      wake_halt,
    output logic      wake_hold,
    output logic      wake_xtal_hold
);
    // Any interrupt releases halt.
    assign wake_halt = any_irq;
    assign wake_hold = (external_irq_line_zero && line_zero_level_mode) |
                       (external_irq_line_one && line_one_level_mode) |
                       external_irq_line_two | external_irq_line_four |
                       external_irq_line_five | port_zero_irq | usb_bus_active_irq;
    assign wake_xtal_hold = wake_hold | base_timer_irq | ir_receiver_irq;
endmodule
`default_nettype wire

// *** verilog/standby_and_reset_control.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "standby_defines.svh"
module standby_and_reset_control
    import standby_pkg::*;
#(
    parameter int unsigned RESTART_CYCLES = `SBY_OSC_RESTART_CYCLES,
    parameter int unsigned STRETCH_CYCLES = `SBY_RESET_STRETCH_CYCLES
) (
    input  wire logic        ref_clk,
    input  wire logic        srst,
    // CPU standby requests, one-cycle pulses.
    input  wire logic        halt_request,
    input  wire logic        hold_request,
    input  wire logic        xtal_hold_request,
    // Reset sources.
    input  wire logic        reset_pin_n,
    input  wire logic        watchdog_reset,
    input  wire logic [12:0] supply_mv,
    input  wire logic [2:0]  por_level_select,
    input  wire logic        supply_drop_enable,
    input  wire logic [2:0]  supply_drop_level_select,
    // Wake sources.
    input  wire logic        any_irq,
    input  wire logic        external_irq_line_zero,
    input  wire logic        external_irq_line_one,
    input  wire logic        external_irq_line_two,
    input  wire logic        external_irq_line_four,
    input  wire logic        external_irq_line_five,
    input  wire logic        line_zero_level_mode,
    input  wire logic        line_one_level_mode,
    input  wire logic        port_zero_irq,
    input  wire logic        usb_bus_active_irq,
    input  wire logic        base_timer_irq,
    input  wire logic        ir_receiver_irq,
    // Software oscillator enables and watchdog control.
    input  wire logic        sw_pll_enable,
    input  wire logic        sw_cf_enable,
    input  wire logic        sw_rc_enable,
    input  wire logic        sw_xtal_enable,
    input  wire logic        watchdog_low_rc_enable,
    input  wire logic        base_timer_on_low_rc,
    // Controls to the core, peripherals and oscillators.
    output logic             cpu_run,
    output logic             periph_run,
    output logic             base_timer_run,
    output logic             ir_receiver_run,
    output logic             pll_enable,
    output logic             ceramic_resonator_oscillator_enable,
    output logic             rc_osc_enable,
    output logic             xtal_osc_enable,
    output logic             low_rc_osc_enable,
    output logic             internal_reset,
    output logic             wake_irq_service
);

    // ----------------------------------------------------------------
    // Parameter checks
    // ----------------------------------------------------------------
    // The down-counter is sixteen bits; longer waits would wrap.
    if (RESTART_CYCLES < 1 || RESTART_CYCLES > 65535) begin : g_bad_restart
        $error("RESTART_CYCLES out of range");
    end
    if (STRETCH_CYCLES < 1 || STRETCH_CYCLES > 65535) begin : g_bad_stretch
        $error("STRETCH_CYCLES out of range");
    end

    localparam logic [15:0] RESTART_LOAD = 16'(RESTART_CYCLES);
    localparam logic [15:0] STRETCH_LOAD = 16'(STRETCH_CYCLES);

    // ----------------------------------------------------------------
    // State
    // ----------------------------------------------------------------
    typedef struct packed {
        sby_state_t  fsm;            // Sequencer state.
        logic [1:0]  pin_sync;       // Reset pin synchroniser.
        logic [15:0] count;          // Restart or reset stretch counter.
        logic        xtal_entry;     // Crystal state caught on entry.
        logic        bt_entry;       // Base timer ran on low RC at entry.
        logic        low_rc_entry;   // Low RC state caught on entry.
        logic        cpu_run;
        logic        periph_run;
        logic        base_timer_run;
        logic        ir_receiver_run;
        logic        pll_enable;
        logic        cf_enable;
        logic        rc_enable;
        logic        xtal_enable;
        logic        low_rc_enable;
        logic        internal_reset;
        logic        wake_irq_service;
    } seq_regs_t;

    seq_regs_t s;       // Registered state.
    seq_regs_t next_s;  // Next state.

    logic supply_reset;    // Combined power-on and drop reset.
    logic wake_halt;       // Halt release by interrupt.
    logic wake_hold;       // Full-hold release by interrupt.
    logic wake_xtal_hold;  // Crystal-hold release by interrupt.
    logic pin_low;         // Synchronised reset pin low.
    logic reset_cause;     // Any reset source active.

    // ----------------------------------------------------------------
    // Submodules
    // ----------------------------------------------------------------
    // Supply monitor: power-on and supply-drop detection.
    supply_reset_gen u_supply (
        .ref_clk                  (ref_clk),
        .srst                     (srst),
        .supply_mv                (supply_mv),
        .por_level_select         (por_level_select),
        .supply_drop_enable       (supply_drop_enable),
        .supply_drop_level_select (supply_drop_level_select),
        .supply_reset             (supply_reset)
    );

    // Wake source qualification per standby mode.
    wake_source_filter u_wake (
        .any_irq                (any_irq),
        .external_irq_line_zero (external_irq_line_zero),
        .external_irq_line_one  (external_irq_line_one),
        .external_irq_line_two  (external_irq_line_two),
        .external_irq_line_four (external_irq_line_four),
        .external_irq_line_five (external_irq_line_five),
        .line_zero_level_mode   (line_zero_level_mode),
        .line_one_level_mode    (line_one_level_mode),
        .port_zero_irq          (port_zero_irq),
        .usb_bus_active_irq     (usb_bus_active_irq),
        .base_timer_irq         (base_timer_irq),
        .ir_receiver_irq        (ir_receiver_irq),
        .wake_halt              (wake_halt),
        .wake_hold              (wake_hold),
        .wake_xtal_hold         (wake_xtal_hold)
    );

    // ----------------------------------------------------------------
    // Reset sources
    // ----------------------------------------------------------------
    // Only the second synchroniser stage is looked at.
    assign pin_low = ~s.pin_sync[1];
    assign reset_cause = pin_low | watchdog_reset | supply_reset;

    // ----------------------------------------------------------------
    // Sequencer
    // ----------------------------------------------------------------
    // Next state and registered outputs, all derived from the next state.
    always_comb begin
        next_s = s;
        next_s.pin_sync = {s.pin_sync[0], reset_pin_n};
        next_s.wake_irq_service = 1'b0;
        if (reset_cause) begin
            next_s.fsm   = ST_RESET;
            next_s.count = STRETCH_LOAD;
        end else begin
            case (s.fsm)
                ST_RUN: begin
                    // Halt wins if several requests coincide.
                    if (halt_request) begin
                        next_s.fsm = ST_HALT;
                    end else if (hold_request) begin
                        next_s.fsm = ST_HOLD;
                    end else if (xtal_hold_request) begin
                        next_s.fsm          = ST_XHOLD;
                        next_s.xtal_entry   = sw_xtal_enable;
                        next_s.bt_entry     = base_timer_on_low_rc;
                        next_s.low_rc_entry = watchdog_low_rc_enable;
                    end
                end
                ST_HALT: begin
                    if (wake_halt) begin
                        next_s.fsm              = ST_RUN;
                        next_s.wake_irq_service = 1'b1;
                    end
                end
                ST_HOLD: begin
                    if (wake_hold) begin
                        next_s.fsm   = ST_RESTART;
                        next_s.count = RESTART_LOAD;
                    end
                end
                ST_XHOLD: begin
                    if (wake_xtal_hold) begin
                        next_s.fsm   = ST_RESTART;
                        next_s.count = RESTART_LOAD;
                    end
                end
                ST_RESTART: begin
                    if (s.count <= `SBY_COUNT_ONE) begin
                        next_s.fsm              = ST_RUN;
                        next_s.count            = `SBY_COUNT_ZERO;
                        next_s.wake_irq_service = 1'b1;
                    end else begin
                        next_s.count = s.count - `SBY_COUNT_ONE;
                    end
                end
                ST_RESET: begin
                    if (s.count <= `SBY_COUNT_ONE) begin
                        next_s.fsm   = ST_RUN;
                        next_s.count = `SBY_COUNT_ZERO;
                    end else begin
                        next_s.count = s.count - `SBY_COUNT_ONE;
                    end
                end
                default: begin
                    next_s.fsm   = ST_RESET;
                    next_s.count = STRETCH_LOAD;
                end
            endcase
        end

        next_s.cpu_run        = (next_s.fsm == ST_RUN);
        next_s.periph_run     = (next_s.fsm == ST_RUN) || (next_s.fsm == ST_HALT);
        next_s.base_timer_run  = next_s.periph_run || (next_s.fsm == ST_XHOLD);
        next_s.ir_receiver_run = next_s.periph_run || (next_s.fsm == ST_XHOLD);
        next_s.internal_reset  = (next_s.fsm == ST_RESET);

        if ((next_s.fsm == ST_HOLD) || (next_s.fsm == ST_XHOLD)) begin
            next_s.pll_enable = 1'b0;
            next_s.cf_enable  = 1'b0;
            next_s.rc_enable  = 1'b0;
        end else begin
            next_s.pll_enable = sw_pll_enable;
            next_s.cf_enable  = sw_cf_enable;
            next_s.rc_enable  = sw_rc_enable;
        end

        case (next_s.fsm)
            ST_HOLD:  next_s.xtal_enable = 1'b0;
            ST_XHOLD: next_s.xtal_enable = next_s.xtal_entry;
            default:  next_s.xtal_enable = sw_xtal_enable;
        endcase

        if ((next_s.fsm == ST_XHOLD) && next_s.bt_entry) begin
            next_s.low_rc_enable = next_s.low_rc_entry;
        end else begin
            next_s.low_rc_enable = watchdog_low_rc_enable;
        end
    end

    // Synchronous reset parks the sequencer in its reset stretch.
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            s <= '{fsm: ST_RESET, pin_sync: 2'h3, count: STRETCH_LOAD,
                   internal_reset: 1'b1, default: 1'b0};
        end else begin
            s <= next_s;
        end
    end

    // ----------------------------------------------------------------
    // Outputs
    // ----------------------------------------------------------------
    assign cpu_run                             = s.cpu_run;
    assign periph_run                          = s.periph_run;
    assign base_timer_run                      = s.base_timer_run;
    assign ir_receiver_run                     = s.ir_receiver_run;
    assign pll_enable                          = s.pll_enable;
    assign ceramic_resonator_oscillator_enable = s.cf_enable;
    assign rc_osc_enable                       = s.rc_enable;
    assign xtal_osc_enable                     = s.xtal_enable;
    assign low_rc_osc_enable                   = s.low_rc_enable;
    assign internal_reset                      = s.internal_reset;
    assign wake_irq_service                    = s.wake_irq_service;

    // ----------------------------------------------------------------
    // Assertions
    // ----------------------------------------------------------------
    property p_halt_stops_cpu;
        @(posedge ref_clk) disable iff (srst)
        (s.fsm == ST_HALT) |-> (!cpu_run && periph_run);
    endproperty
    a_halt_stops_cpu: assert property (p_halt_stops_cpu) else $error("halt state wrong");

    property p_halt_keeps_osc;
        @(posedge ref_clk) disable iff (srst)
        (s.fsm == ST_HALT) |-> (pll_enable == $past(sw_pll_enable)) && (xtal_osc_enable == $past(sw_xtal_enable));
    endproperty
    a_halt_keeps_osc: assert property (p_halt_keeps_osc) else $error("halt changed oscillator");

    property p_halt_wake;
        @(posedge ref_clk) disable iff (srst)
        (s.fsm == ST_HALT) && wake_halt && !reset_cause |=> cpu_run && wake_irq_service;
    endproperty
    a_halt_wake: assert property (p_halt_wake) else $error("halt not released");

    property p_hold_all_off;
        @(posedge ref_clk) disable iff (srst)
        (s.fsm == ST_HOLD) |-> !periph_run && !pll_enable && !ceramic_resonator_oscillator_enable
                               && !rc_osc_enable && !xtal_osc_enable;
    endproperty
    a_hold_all_off: assert property (p_hold_all_off) else $error("hold left clock running");

    property p_hold_wake;
        @(posedge ref_clk) disable iff (srst)
        (s.fsm == ST_HOLD) && wake_hold && !reset_cause |=> (s.fsm == ST_RESTART) && !cpu_run;
    endproperty
    a_hold_wake: assert property (p_hold_wake) else $error("hold not released");

    property p_xhold_units;
        @(posedge ref_clk) disable iff (srst)
        (s.fsm == ST_XHOLD) |-> base_timer_run && ir_receiver_run && !periph_run && !pll_enable;
    endproperty
    a_xhold_units: assert property (p_xhold_units) else $error("crystal hold units wrong");

    property p_xhold_xtal;
        @(posedge ref_clk) disable iff (srst)
        (s.fsm == ST_XHOLD) |-> (xtal_osc_enable == s.xtal_entry);
    endproperty
    a_xhold_xtal: assert property (p_xhold_xtal) else $error("crystal state lost");

    property p_xhold_low_rc;
        @(posedge ref_clk) disable iff (srst)
        (s.fsm == ST_XHOLD) && s.bt_entry |-> (low_rc_osc_enable == s.low_rc_entry);
    endproperty
    a_xhold_low_rc: assert property (p_xhold_low_rc) else $error("low RC state lost");

    property p_restart_resume;
        @(posedge ref_clk) disable iff (srst)
        (s.fsm == ST_RESTART) && (s.count == `SBY_COUNT_ONE) && !reset_cause |=> cpu_run && wake_irq_service;
    endproperty
    a_restart_resume: assert property (p_restart_resume) else $error("no resume after restart");

    property p_reset_follows;
        @(posedge ref_clk) disable iff (srst)
        reset_cause |=> internal_reset && !cpu_run;
    endproperty
    a_reset_follows: assert property (p_reset_follows) else $error("reset not asserted");

endmodule
`default_nettype wire

// *** dv/wake_partner.sv ***
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------------------------------
// Wake source model
// ----------------------------------------------------------------
module wake_partner (
    input  wire logic       ref_clk,
    input  wire logic [8:0] raise,
    output logic            any_irq,
    output logic [8:0]      irq
);
    // Sources are level requests, registered as a peripheral would drive them.
    // wake sources
    always_ff @(posedge ref_clk) begin
        irq     <= raise;
        any_irq <= |raise;
    end
endmodule
`default_nettype wire

// *** dv/tb_top.sv ***
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    logic ref_clk = 0, srst = 1, hr = 0, hq = 0, xq = 0, pin_n = 1, wd = 0, de = 0, lz = 0, lo = 0;
    logic sx = 1, sp = 1, sc = 1, sr = 1, wlr = 1, btl = 0, cpu, per, btr, irr, pll, cf, rc, xt, lrc, ir, svc, anyi;
    logic [12:0] mv = 13'h0000;
    logic [8:0] raise = 9'h000, irq;
    int n_errors = 0, n_compared = 0;
    always #20 ref_clk = ~ref_clk;
    wake_partner i_src (.ref_clk(ref_clk), .raise(raise), .any_irq(anyi), .irq(irq));
    standby_and_reset_control #(.RESTART_CYCLES(4), .STRETCH_CYCLES(2)) i_dut (.ref_clk(ref_clk), .srst(srst),
        .halt_request(hr), .hold_request(hq), .xtal_hold_request(xq), .reset_pin_n(pin_n), .watchdog_reset(wd),
        .supply_mv(mv), .por_level_select(3'h0), .supply_drop_enable(de), .supply_drop_level_select(3'h0),
        .any_irq(anyi), .external_irq_line_zero(irq[0]), .external_irq_line_one(irq[1]),
        .external_irq_line_two(irq[2]), .external_irq_line_four(irq[3]), .external_irq_line_five(irq[4]),
        .line_zero_level_mode(lz), .line_one_level_mode(lo), .port_zero_irq(irq[5]), .usb_bus_active_irq(irq[6]),
        .base_timer_irq(irq[7]), .ir_receiver_irq(irq[8]), .sw_pll_enable(sp), .sw_cf_enable(sc),
        .sw_rc_enable(sr), .sw_xtal_enable(sx), .watchdog_low_rc_enable(wlr), .base_timer_on_low_rc(btl),
        .cpu_run(cpu), .periph_run(per), .base_timer_run(btr), .ir_receiver_run(irr), .pll_enable(pll),
        .ceramic_resonator_oscillator_enable(cf), .rc_osc_enable(rc), .xtal_osc_enable(xt),
        .low_rc_osc_enable(lrc), .internal_reset(ir), .wake_irq_service(svc));
    // Compare a settled value and count the outcome.
    task chk(input logic [7:0] got, input logic [7:0] exp);
        n_compared++;
        if (got !== exp) begin
            n_errors++;
            $display("Error t=%0t got %h exp %h", $time, got, exp);
        end
    endtask
    task cyc(input int n);
        repeat (n) @(posedge ref_clk);
        #1;
    endtask
    // Bounded wait so a stuck sequencer ends as a mismatch, not a hang.
    // The service pulse stands only in the first run cycle, so it is judged there.
    task wait_run(input logic exp_svc);
        for (int i = 0; i < 100 && cpu !== 1'b1; i++) cyc(1);
        chk({cpu, per, pll, cf, rc, xt, svc, 1'b0}, {6'h3F, exp_svc, 1'b0});
    endtask
    // One-cycle request pulse; order is halt, hold, crystal hold.
    task pulse(input logic [2:0] r);
        @(posedge ref_clk) {hr, hq, xq} <= r;
        @(posedge ref_clk) {hr, hq, xq} <= 3'h0;
        #1;
    endtask
    task t_halt;
        @(posedge ref_clk) {sp, sc, sr} <= 3'h0;
        pulse(3'h4);
        chk({cpu, per, pll, cf, rc, xt, 2'b00}, 8'h44);
        @(posedge ref_clk) begin
            raise <= 9'h004;
            {sp, sc, sr} <= 3'h7;
        end
        wait_run(1'b1);
        @(posedge ref_clk) raise <= 9'h000;
        cyc(3);
    endtask
    task t_hold;
        pulse(3'h2);
        chk({cpu, per, pll, cf, rc, xt, 2'b00}, 8'h00);
        @(posedge ref_clk) begin
            raise <= 9'h181;
            wlr <= 0;
        end
        cyc(10);
        chk({6'h00, lrc, cpu}, 8'h00);
        @(posedge ref_clk) begin
            lz <= 1;
            wlr <= 1;
        end
        wait_run(1'b1);
        @(posedge ref_clk) raise <= 9'h000;
        cyc(3);
    endtask
    task t_xhold;
        @(posedge ref_clk) begin
            sx <= 0;
            btl <= 1;
        end
        pulse(3'h1);
        chk({cpu, per, pll, cf, rc, xt, btr, irr}, 8'h03);
        @(posedge ref_clk) begin
            sx <= 1;
            wlr <= 0;
        end
        cyc(3);
        chk({6'h00, xt, lrc}, 8'h01);
        @(posedge ref_clk) raise <= 9'h080;
        wait_run(1'b1);
        @(posedge ref_clk) raise <= 9'h000;
        wlr <= 1;
        cyc(3);
    endtask
    // One wake source alone; bits above six are crystal-hold-only sources.
    task t_wake(input int b);
        pulse((b > 6) ? 3'h1 : 3'h2);
        @(posedge ref_clk) raise <= 9'h001 << b;
        wait_run(1'b1);
        @(posedge ref_clk) raise <= 9'h000;
        cyc(3);
    endtask
    task t_reset;
        pulse(3'h2);
        @(posedge ref_clk) wd <= 1;
        cyc(3);
        chk({6'h00, ir, cpu}, 8'h02);
        @(posedge ref_clk) wd <= 0;
        wait_run(1'b0);
        @(posedge ref_clk) pin_n <= 0;
        cyc(5);
        chk({6'h00, ir, cpu}, 8'h02);
        @(posedge ref_clk) pin_n <= 1;
        wait_run(1'b0);
        @(posedge ref_clk) de <= 1;
        mv <= 13'h0708;
        cyc(5);
        chk({6'h00, ir, cpu}, 8'h02);
        @(posedge ref_clk) mv <= 13'h0CE4;
        wait_run(1'b0);
    endtask
    task report_and_stop;
        $display("errors %0d compared %0d", n_errors, n_compared);
        if (n_errors == 0 && n_compared > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask
    initial begin
        repeat (6) @(posedge ref_clk);
        srst <= 0;
        cyc(10);
        chk({6'h00, ir, cpu}, 8'h02);
        @(posedge ref_clk) mv <= 13'h0CE4;
        wait_run(1'b0);
        t_halt();
        t_hold();
        t_xhold();
        @(posedge ref_clk) lo <= 1;
        for (int b = 1; b < 9; b++) begin
            t_wake(b);
        end
        t_reset();
        report_and_stop();
    end
    initial begin
        #400000;
        n_errors++;
        report_and_stop();
    end
endmodule
`default_nettype wire
